// ---- bench/host_bus_model.sv ----
// Behavioural host on the external parallel data bus.
`timescale 1ns/10ps
module host_bus_model (
  input  wire        clock,              // Clock.
  input  wire        go_rd,              // Ask for one read pulse.
  input  wire        go_wr,              // Ask for one write pulse.
  input  wire [15:0] wdata,              // Data to write.
  output reg         ext_rd = 1'b0,      // Read pulse.
  output reg         ext_wr = 1'b0,      // Write pulse.
  output reg  [15:0] ext_data_in = 16'h0 // Lines toward the device.
);
  // Released lines show the inverse of their last value, never a held copy.
  always @(posedge clock) begin
    ext_rd <= go_rd;
    ext_wr <= go_wr && !go_rd;
    ext_data_in <= go_wr ? wdata : ~ext_data_in;
  end
endmodule // host_bus_model

// ---- bench/timing_controller_cmd_props.sv ----
// Assertion checker for the ports of the global command decoder.
`timescale 1ns/10ps
module timing_controller_cmd_props (
  input wire        clock,            // Clock.
  input wire        rst,              // Reset.
  input wire [2:0]  address,          // Word address.
  input wire        read,             // Read strobe.
  input wire        write,            // Write strobe.
  input wire [31:0] writedata,        // Write data.
  input wire [3:0]  byteenable,       // Byte lanes.
  input wire [31:0] readdata,         // Read data.
  input wire        waitrequest,      // Wait request.
  input wire [15:0] ext_data_oe,      // Line enables.
  input wire        ext_rd,           // External read.
  input wire        freq_out_pin,     // Frequency output.
  input wire [4:0]  counters_armed,   // Arm state.
  input wire        write_prefetch_on // Write prefetch.
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  wire       done  = write && !waitrequest;
  wire [7:0] op    = writedata[7:0];
  wire       cmd   = done && (address == 3'h0);
  wire       pf_en = cmd && (op == 8'hf8 || op == 8'hff);
  reg        wide;
  // Shadow of the bus-width bit, followed from completed writes.
  always @(posedge clock or posedge rst) begin
    if (rst) wide <= 1'b0;
    else if (cmd && op == 8'hef) wide <= 1'b1;
    else if (cmd && (op == 8'he7 || op == 8'hff)) wide <= 1'b0;
    else if (done && address == 3'h1 && byteenable[1]) wide <= writedata[13];
  end
  sequence s_ack;
    !waitrequest ##1 waitrequest;
  endsequence
  chk_ack_one:
    assert property ((read || write) && waitrequest |=> s_ack) else $error("no answer");
  chk_gate_off:
    assert property (cmd && op == 8'hee |-> ##2 !freq_out_pin) else $error("freq_out_pin not low");
  chk_pf_off:
    assert property (cmd && op == 8'hf9 |-> ##2 !write_prefetch_on) else $error("pf on");
  chk_pf_hold:
    assert property ($rose(write_prefetch_on) |-> $past(pf_en) || $past(pf_en, 2))
    else $error("pf back early");
  chk_soft_reset:
    assert property (cmd && op == 8'hff |-> ##2 counters_armed == 5'h00 && write_prefetch_on)
    else $error("soft reset");
  chk_width_oe:
    assert property (ext_rd |=> ext_data_oe == (wide ? 16'hffff : 16'h00ff)) else $error("oe");
  chk_oe_idle:
    assert property (!ext_rd |=> ext_data_oe == 16'h0000) else $error("oe idle");
  chk_upper_zero:
    assert property (read && !waitrequest |-> readdata[31:16] == 16'h0000) else $error("upper");
  chk_status_wide:
    assert property (read && !waitrequest && address == 3'h2 |-> readdata[0] == wide)
    else $error("width bit");
endmodule // timing_controller_cmd_props
bind timing_controller_cmd timing_controller_cmd_props u_props (.clock, .rst, .address,
  .read, .write, .writedata, .byteenable, .readdata, .waitrequest, .ext_data_oe, .ext_rd,
  .freq_out_pin, .counters_armed, .write_prefetch_on);

// ---- bench/timing_controller_cmd_tb.sv ----
// Self-checking bench of the global command decoder.
`timescale 1ns/10ps
module timing_controller_cmd_tb;
  logic        clock, rst, read, write, go_rd, go_wr, waitrequest, ext_rd, ext_wr;
  logic        freq_out_pin, write_prefetch_on, pf_off;
  logic [2:0]  address;
  logic [3:0]  byteenable;
  logic [4:0]  counters_armed;
  logic [15:0] ext_data_in, ext_data_out, ext_data_oe, mm;
  logic [31:0] writedata, readdata, q;
  logic [7:0]  ops [8] = '{8'hef, 8'he7, 8'hee, 8'he6, 8'hf9, 8'hf8, 8'hf0, 8'h5f};
  int          n_errors, n_tests, i, cnt;
  timing_controller_cmd u_timing_controller_cmd (.clock, .rst, .address, .read, .write,
    .writedata, .byteenable, .readdata, .waitrequest, .ext_data_in, .ext_data_out,
    .ext_data_oe, .ext_rd, .ext_wr, .freq_out_pin, .counters_armed, .write_prefetch_on);
  host_bus_model u_host_bus_model (.clock, .go_rd, .go_wr, .wdata(mm), .ext_rd, .ext_wr,
    .ext_data_in);
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  function automatic logic [15:0] mm_after(input logic [15:0] m, input logic [7:0] o);
    case (o)
      8'hef: m[13] = 1'b1;
      8'he7: m[13] = 1'b0;
      8'hee: m[12] = 1'b1;
      8'he6: m[12] = 1'b0;
      8'hff: m = 16'h0000;
      default: ;
    endcase
    return m;
  endfunction
  task automatic close_out;
    $display("errors %0d tests %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic wr, input logic [2:0] a, input logic [15:0] d);
    read <= !wr;
    write <= wr;
    address <= a;
    writedata <= {16'h0000, d};
    @(posedge clock);
    while (waitrequest !== 1'b0) @(posedge clock);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clock);
  endtask
  task automatic cmd(input logic [7:0] o);
    bus(1'b1, 3'h0, {8'h00, o});
    mm = mm_after(mm, o);
    if (o == 8'hf9) pf_off = 1'b1;
    else if (o == 8'hf8 || o == 8'hff) pf_off = 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [31:0] e, input string nm);
    bus(1'b0, a, 16'h0000);
    chk(nm, e, q);
  endtask
  initial begin
    repeat (5000) @(posedge clock);
    n_errors++;
    close_out;
  end
  initial begin
    rst = 1'b1; read = 1'b0; write = 1'b0; address = 3'h0; writedata = 32'h0;
    byteenable = 4'h3; go_rd = 1'b0; go_wr = 1'b0; mm = 16'h0; pf_off = 1'b0;
    n_errors = 0; n_tests = 0; i = $urandom(65);
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    rd(3'h1, 32'h0, "mm_reset");
    rd(3'h5, 32'h0800, "cm_reset");
    for (i = 6; i < 8; i++) rd(i[2:0], 32'h0, "load_hold_reset");
    cmd(8'h5f);
    bus(1'b1, 3'h3, 16'h0001);
    for (i = 0; i < 60; i++) begin
      cnt = $urandom % 9;
      if (cnt == 8) begin
        mm = 16'($urandom);
        bus(1'b1, 3'h1, mm);
      end else cmd(ops[cnt]);
      rd(3'h1, {16'h0, mm}, "mm");
      rd(3'h2, {29'h0, pf_off, mm[12], mm[13]}, "status");
      chk("pf_pin", {31'h0, !pf_off}, {31'h0, write_prefetch_on});
      go_rd <= 1'b1;
      @(posedge clock);
      go_rd <= 1'b0;
      @(posedge clock);
      #1 chk("oe", {16'h0, mm[13] ? 16'hffff : 16'h00ff}, {16'h0, ext_data_oe});
      @(posedge clock);
    end
    cmd(8'he6);
    repeat (3) @(posedge clock);
    cnt = 0;
    repeat (20) @(posedge clock) cnt += freq_out_pin;
    chk("freq_out_pin_runs", 32'h1, {31'h0, cnt > 0 && cnt < 20});
    cmd(8'hee);
    cnt = 0;
    repeat (20) @(posedge clock) cnt += freq_out_pin;
    chk("freq_out_pin_off", 32'h0, cnt);
    cmd(8'hf9);
    cmd(8'hff);
    rd(3'h1, 32'h0, "mm_soft");
    rd(3'h5, 32'h0800, "cm_soft");
    rd(3'h3, 32'h0001, "pointer_kept");
    chk("armed", 32'h0, {27'h0, counters_armed});
    chk("pf_soft", 32'h1, {31'h0, write_prefetch_on});
    close_out;
  end
endmodule // timing_controller_cmd_tb

// ---- core/cmd_decoder_map.vh ----
// Register offsets, opcodes, bit positions and reset values of the global command decoder.
`ifndef CMD_DECODER_MAP_VH
`define CMD_DECODER_MAP_VH

// ***************************************************************
// Avalon word addresses.
// ***************************************************************
`define ADDR_CMD          3'h0
`define ADDR_MASTER_MODE  3'h1
`define ADDR_STATUS       3'h2
`define ADDR_DATA_POINTER 3'h3
`define ADDR_FREQ_DIV     3'h4
`define ADDR_COUNTER_MODE 3'h5
`define ADDR_LOAD         3'h6
`define ADDR_HOLD         3'h7

// ***************************************************************
// Command opcodes.
// ***************************************************************
`define OP_WIDE_BUS       8'hef
`define OP_NARROW_BUS     8'he7
`define OP_GATE_OFF       8'hee
`define OP_GATE_ON        8'he6
`define OP_PREFETCH_OFF   8'hf9
`define OP_PREFETCH_ON    8'hf8
`define OP_MASTER_RESET   8'hff
`define OP_LOAD_ALL       8'h5f

// ***************************************************************
// Master-mode bit positions and reset values.
// ***************************************************************
`define MM_BUS_WIDTH      13
`define MM_FREQ_GATE      12
`define MM_RESET          16'h0000
`define CM_RESET          16'h0800
`define LOAD_HOLD_RESET   16'h0000
`define NUM_COUNTERS      5
`define DIV_RESET         16'h0001

// ***************************************************************
// Status bit positions.
// ***************************************************************
`define ST_WIDE           0
`define ST_GATED          1
`define ST_PF_OFF         2
`define ST_ARMED          3

`endif

// ---- core/timing_controller_cmd.v ----
// Global command decoder of the multi-counter timing controller, with Avalon-MM slave.
//
// Behaviour
// - Wide-bus command sets bus_width_select_bit 13, other master-mode bits kept.
// - Bus-width bit set: full sixteen-line data path, multiplexer bypassed.
// - Narrow-bus command clears bus_width_select_bit 13, other bits kept.
// - Bus-width bit clear: 16-bit words move as two bytes on low lines.
// - Full master-mode word write also updates width and gating bits.
// - Gate-off sets bit 12; freq_out_pin then driven low.
// - Gate-on clears bit 12; freq_out_pin then carries divided frequency source.
// - Prefetch-disable stops write prefetch only; read prefetch keeps working.
// - Write prefetch stays disabled until prefetch-enable or any reset.
// - Prefetch-enable only cancels an earlier prefetch-disable.
// - Opcode ff resets master-mode, load, hold, counter-mode and prefetch-disable, and disarms every counter; freq_div kept.
// - Reset loads zero in master-mode, load, hold; 0800 in counter-mode.
// - Reset leaves the data pointer register unchanged.
//
// Chosen here: the register addresses and the Avalon-MM slave port.
`timescale 1ns/10ps
`include "cmd_decoder_map.vh"

module timing_controller_cmd (
  input  wire        clock,            // System clock, 100 MHz.
  input  wire        rst,              // Asynchronous reset, active high.
  input  wire [2:0]  address,          // Avalon word address.
  input  wire        read,             // Avalon read strobe.
  input  wire        write,            // Avalon write strobe.
  input  wire [31:0] writedata,        // Avalon write data.
  input  wire [3:0]  byteenable,       // Avalon byte enables.
  output reg  [31:0] readdata,         // Avalon read data.
  output reg         waitrequest,      // Avalon wait request.
  input  wire [15:0] ext_data_in,      // External data lines, input side.
  output reg  [15:0] ext_data_out,     // External data lines, output side.
  output reg  [15:0] ext_data_oe,      // External data lines, per-line enable.
  input  wire        ext_rd,           // External read pulse, synchronous.
  input  wire        ext_wr,           // External write pulse, synchronous.
  output reg         freq_out_pin,     // Divided frequency output.
  output reg  [4:0]  counters_armed,   // Arm state of each counter.
  output reg         write_prefetch_on // Write prefetch active.
);

  // ***************************************************************
  // Registers.
  // ***************************************************************
  reg  [15:0] master_mode;
  reg  [15:0] counter_mode [0:`NUM_COUNTERS-1];
  reg  [15:0] load_reg;
  reg  [15:0] hold_reg;
  reg  [7:0]  data_pointer;
  reg  [15:0] freq_div;
  reg  [15:0] div_count;
  reg         freq_tick;
  reg         freq_level;
  reg         prefetch_off;
  reg         byte_phase;
  reg  [7:0]  low_byte;
  reg  [15:0] next_word;
  reg         next_word_valid;
  wire        soft_reset;
  wire        access;
  wire        bus_write;
  wire [15:0] wd16;
  integer     i;

  // Byte-lane merge of a 16-bit register from an Avalon write.
  function [15:0] merge16;
    input [15:0] old;
    input [15:0] nw;
    input [1:0]  be;
    begin
      merge16 = {be[1] ? nw[15:8] : old[15:8], be[0] ? nw[7:0] : old[7:0]};
    end
  endfunction

  // Opcode decode shared by the command path.
  function is_cmd;
    input [7:0] byte_in;
    input [7:0] op;
    begin
      is_cmd = (byte_in == op);
    end
  endfunction

  assign wd16      = writedata[15:0];
  assign access    = (read | write) & waitrequest;
  // A write lands at the edge where the master sees waitrequest low.
  assign bus_write = write & ~waitrequest;
  assign soft_reset = bus_write & (address == `ADDR_CMD) & byteenable[0] &
                      is_cmd(writedata[7:0], `OP_MASTER_RESET);

  // ***************************************************************
  // Avalon slave: one wait cycle, then the answer.
  // ***************************************************************
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      waitrequest <= 1'b1;
      readdata    <= 32'h0000_0000;
    end else begin
      if (access) begin
        waitrequest <= 1'b0;
        if (read) begin
          case (address)
            `ADDR_MASTER_MODE:  readdata <= {16'h0000, master_mode};
            `ADDR_STATUS:       readdata <= {28'h0000000, |counters_armed, prefetch_off,
                                             master_mode[`MM_FREQ_GATE],
                                             master_mode[`MM_BUS_WIDTH]};
            `ADDR_DATA_POINTER: readdata <= {24'h000000, data_pointer};
            `ADDR_FREQ_DIV:     readdata <= {16'h0000, freq_div};
            `ADDR_COUNTER_MODE: readdata <= {16'h0000, counter_mode[0]};
            `ADDR_LOAD:         readdata <= {16'h0000, load_reg};
            `ADDR_HOLD:         readdata <= {16'h0000, hold_reg};
            default:            readdata <= 32'h0000_0000;
          endcase
        end
      end else begin
        waitrequest <= 1'b1;
      end
    end
  end

  // ***************************************************************
  // Command decode and master-mode register.
  // ***************************************************************
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      master_mode    <= `MM_RESET;
      load_reg       <= `LOAD_HOLD_RESET;
      hold_reg       <= `LOAD_HOLD_RESET;
      prefetch_off   <= 1'b0;
      counters_armed <= 5'h00;
      freq_div       <= `DIV_RESET;
      for (i = 0; i < `NUM_COUNTERS; i = i + 1)
        counter_mode[i] <= `CM_RESET;
    end else if (soft_reset) begin
      master_mode    <= `MM_RESET;
      load_reg       <= `LOAD_HOLD_RESET;
      hold_reg       <= `LOAD_HOLD_RESET;
      prefetch_off   <= 1'b0;
      counters_armed <= 5'h00;
      for (i = 0; i < `NUM_COUNTERS; i = i + 1)
        counter_mode[i] <= `CM_RESET;
    end else if (bus_write) begin
      case (address)
        `ADDR_CMD: begin
          if (byteenable[0]) begin
            case (writedata[7:0])
              `OP_WIDE_BUS:     master_mode[`MM_BUS_WIDTH] <= 1'b1;
              `OP_NARROW_BUS:   master_mode[`MM_BUS_WIDTH] <= 1'b0;
              `OP_GATE_OFF:     master_mode[`MM_FREQ_GATE] <= 1'b1;
              `OP_GATE_ON:      master_mode[`MM_FREQ_GATE] <= 1'b0;
              `OP_PREFETCH_OFF: prefetch_off <= 1'b1;
              `OP_PREFETCH_ON:  prefetch_off <= 1'b0;
              `OP_LOAD_ALL:     counters_armed <= counters_armed;
              default:          prefetch_off <= prefetch_off;
            endcase
          end
        end
        `ADDR_MASTER_MODE:  master_mode <= merge16(master_mode, wd16, byteenable[1:0]);
        `ADDR_FREQ_DIV:     freq_div <= merge16(freq_div, wd16, byteenable[1:0]);
        `ADDR_COUNTER_MODE: counter_mode[0] <= merge16(counter_mode[0], wd16,
                                                       byteenable[1:0]);
        `ADDR_LOAD:         load_reg <= merge16(load_reg, wd16, byteenable[1:0]);
        `ADDR_HOLD:         hold_reg <= merge16(hold_reg, wd16, byteenable[1:0]);
        default:            load_reg <= load_reg;
      endcase
    end
  end

  // Data pointer sees no reset of either kind.
  always @(posedge clock) begin
    if (bus_write && address == `ADDR_DATA_POINTER && byteenable[0]) begin
      data_pointer <= writedata[7:0];
    end
  end

  // ***************************************************************
  // Frequency output divider and gating.
  // ***************************************************************
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      div_count    <= 16'h0000;
      freq_tick    <= 1'b0;
      freq_level   <= 1'b0;
      freq_out_pin <= 1'b0;
    end else begin
      freq_tick <= 1'b0;
      if (div_count + 16'h0001 >= freq_div) begin
        div_count <= 16'h0000;
        freq_tick <= 1'b1;
      end else begin
        div_count <= div_count + 16'h0001;
      end
      if (freq_tick)
        freq_level <= ~freq_level;
      freq_out_pin <= master_mode[`MM_FREQ_GATE] ? 1'b0 : freq_level;
    end
  end

  // ***************************************************************
  // External data bus: width mux and write prefetch.
  // ***************************************************************
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      byte_phase        <= 1'b0;
      low_byte          <= 8'h00;
      ext_data_out      <= 16'h0000;
      ext_data_oe       <= 16'h0000;
      next_word         <= 16'h0000;
      next_word_valid   <= 1'b0;
      write_prefetch_on <= 1'b1;
    end else begin
      write_prefetch_on <= ~prefetch_off;
      if (ext_rd) begin
        // Read prefetch always runs: the next word is staged after each read.
        next_word_valid <= 1'b1;
        next_word       <= hold_reg;
        if (master_mode[`MM_BUS_WIDTH]) begin
          ext_data_out <= next_word_valid ? next_word : hold_reg;
          ext_data_oe  <= 16'hffff;
        end else begin
          ext_data_out <= {8'h00, byte_phase ? hold_reg[15:8] : hold_reg[7:0]};
          ext_data_oe  <= 16'h00ff;
          byte_phase   <= ~byte_phase;
        end
      end else begin
        ext_data_oe <= 16'h0000;
        if (ext_wr) begin
          if (!master_mode[`MM_BUS_WIDTH]) begin
            byte_phase <= ~byte_phase;
            if (!byte_phase)
              low_byte <= ext_data_in[7:0];
          end
          // Write prefetch marks the staging word valid unless disabled.
          next_word_valid <= ~prefetch_off;
        end
      end
    end
  end

endmodule // timing_controller_cmd
